// File: timebase_regs.svh
// register map, field positions and reset values of the timebase block
// assumes an 8-bit special-function register space addressed by byte
`ifndef TIMEBASE_REGS_SVH
`define TIMEBASE_REGS_SVH

// =========================================================
// register addresses
`define MICROSECOND_PRESCALER_ADDR    8'hfb
`define MILLISECOND_DIVIDER_LOW_ADDR  8'hfc
`define MILLISECOND_DIVIDER_HIGH_ADDR 8'hfd
`define HUNDRED_MS_DIVIDER_ADDR       8'hfe
`define WATCHDOG_CONTROL_ADDR         8'hff

// =========================================================
// reset values
`define MICROSECOND_PRESCALER_RST     8'h03
`define MILLISECOND_DIVIDER_LOW_RST   8'h9f
`define MILLISECOND_DIVIDER_HIGH_RST  8'h0f
`define HUNDRED_MS_DIVIDER_RST        8'h63
`define WATCHDOG_CONTROL_RST          8'h00

// =========================================================
// field positions
`define PRESCALER_VALUE_MSB           4
`define WATCHDOG_ENABLE_BIT           7
`define WATCHDOG_DISABLE_BIT          6
`define WATCHDOG_RESTART_BIT          5
`define WATCHDOG_COUNT_MSB            4
`define WATCHDOG_SEQ_BITS             3
`define SEQ_RESTART_IDX               0
`define SEQ_DISABLE_IDX               1
`define SEQ_ENABLE_IDX                2

`endif

// File: timebase_pkg.sv
// types shared by the timebase and watchdog modules
// assumes nothing beyond a SystemVerilog package scope
package timebase_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [4:0]  microsecond_prescaler_div_t;
	typedef logic [15:0] msec_div_t;
	typedef logic [5:0]  wd_count_t;

	typedef enum logic [1:0] {
		WD_IDLE,
		WD_COUNTING,
		WD_EXPIRED
	} wd_state_t;

endpackage

// File: timebase_if.sv
// carrier between the register block and the divider chain
// assumes both ends run on the one system clock
`timescale 1ns/100ps

interface timebase_if;
	logic [4:0]  microsecond_prescaler_div;
	logic [15:0] msec_div;
	logic [7:0]  hms_div;
	logic        run;
	logic        microsecond_prescaler_tick;
	logic        msec_tick;
	logic        hms_tick;

	modport ctrl (
		output microsecond_prescaler_div,
		output msec_div,
		output hms_div,
		output run,
		input  microsecond_prescaler_tick,
		input  msec_tick,
		input  hms_tick
	);

	modport gen (
		input  microsecond_prescaler_div,
		input  msec_div,
		input  hms_div,
		input  run,
		output microsecond_prescaler_tick,
		output msec_tick,
		output hms_tick
	);
endinterface

// File: timebase_divider_chain.sv
// divider chain: system clock to 1 us, 1 ms and 100 ms ticks
// assumes divisors are stable registers on the same clock
`timescale 1ns/100ps

module timebase_divider_chain (
	// clock and reset
	input  wire logic  mclk_in,
	input  wire logic  sys_rst_in,
	// divisors in, ticks out
	timebase_if.gen    tb
);
	import timebase_pkg::*;

	// =========================================================
	// counters
	logic [4:0]  microsecond_prescaler_cnt_reg;
	logic [4:0]  microsecond_prescaler_cnt_next;
	logic [15:0] msec_cnt_reg;
	logic [15:0] msec_cnt_next;
	logic [7:0]  hms_cnt_reg;
	logic [7:0]  hms_cnt_next;
	logic        microsecond_prescaler_wrap;
	logic        msec_wrap;
	logic        hms_wrap;

	// >= rather than == so a divisor lowered mid-count wraps at once
	assign microsecond_prescaler_wrap = (microsecond_prescaler_cnt_reg >= tb.microsecond_prescaler_div);
	assign msec_wrap = (msec_cnt_reg >= tb.msec_div);
	assign hms_wrap  = msec_wrap && (hms_cnt_reg >= tb.hms_div);

	assign microsecond_prescaler_cnt_next = microsecond_prescaler_wrap ? 5'h00 : microsecond_prescaler_cnt_reg + 5'h01;
	assign msec_cnt_next = msec_wrap ? 16'h0000 : msec_cnt_reg + 16'h0001;
	assign hms_cnt_next  = !msec_wrap ? hms_cnt_reg :
		(hms_wrap ? 8'h00 : hms_cnt_reg + 8'h01);

	// power-down parks every counter at zero, no ticks
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			microsecond_prescaler_cnt_reg <= 5'h00;
			msec_cnt_reg <= 16'h0000;
			hms_cnt_reg  <= 8'h00;
			tb.microsecond_prescaler_tick <= 1'b0;
			tb.msec_tick <= 1'b0;
			tb.hms_tick  <= 1'b0;
		end else if (!tb.run) begin
			microsecond_prescaler_cnt_reg <= 5'h00;
			msec_cnt_reg <= 16'h0000;
			hms_cnt_reg  <= 8'h00;
			tb.microsecond_prescaler_tick <= 1'b0;
			tb.msec_tick <= 1'b0;
			tb.hms_tick  <= 1'b0;
		end else begin
			microsecond_prescaler_cnt_reg <= microsecond_prescaler_cnt_next;
			msec_cnt_reg <= msec_cnt_next;
			hms_cnt_reg  <= hms_cnt_next;
			tb.microsecond_prescaler_tick <= microsecond_prescaler_wrap;
			tb.msec_tick <= msec_wrap;
			tb.hms_tick  <= hms_wrap;
		end
	end

endmodule

// File: timebase_prescaler_watchdog.sv
// system timebase with tick outputs and a software-guarded watchdog
// assumes the core drives sfr strobes on mclk_in; power-down bits are
// driven by the power control register on the same clock
`timescale 1ns/100ps
`include "timebase_regs.svh"

module timebase_prescaler_watchdog (
	// clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 sys_rst_in,
	// special-function register port
	input  wire timebase_pkg::byte_t  sfr_addr_in,
	input  wire logic                 sfr_wr_in,
	input  wire timebase_pkg::byte_t  sfr_wdata_in,
	input  wire logic                 sfr_rd_in,
	output timebase_pkg::byte_t       sfr_rdata_out,
	// power-down controls
	input  wire logic                 watchdog_power_down_in,
	input  wire logic                 timebase_power_down_in,
	// ticks to the flash timer and other users
	output logic                      microsecond_prescaler_tick_out,
	output logic                      msec_tick_out,
	output logic                      hms_tick_out,
	// watchdog status and event
	output logic                      watchdog_counting_out,
	output logic                      watchdog_event_out
);
	import timebase_pkg::*;

	timebase_if tb_bus ();

	// =========================================================
	// register file
	byte_t microsecond_prescaler_reg;
	byte_t millisecond_divider_low_reg;
	byte_t millisecond_divider_high_reg;
	byte_t hms_reg;
	byte_t wdctl_reg;

	logic  hit_microsecond_prescaler;
	logic  hit_millisecond_divider_low;
	logic  hit_millisecond_divider_high;
	logic  hit_hms;
	logic  hit_wdctl;
	logic  wr_microsecond_prescaler;
	logic  wr_millisecond_divider_low;
	logic  wr_millisecond_divider_high;
	logic  wr_hms;
	logic  wr_wdctl;

	// one address compare per register, shared by write and read
	assign hit_microsecond_prescaler  = (sfr_addr_in == `MICROSECOND_PRESCALER_ADDR);
	assign hit_millisecond_divider_low = (sfr_addr_in == `MILLISECOND_DIVIDER_LOW_ADDR);
	assign hit_millisecond_divider_high = (sfr_addr_in == `MILLISECOND_DIVIDER_HIGH_ADDR);
	assign hit_hms   = (sfr_addr_in == `HUNDRED_MS_DIVIDER_ADDR);
	assign hit_wdctl = (sfr_addr_in == `WATCHDOG_CONTROL_ADDR);

	assign wr_microsecond_prescaler  = sfr_wr_in && hit_microsecond_prescaler;
	assign wr_millisecond_divider_low = sfr_wr_in && hit_millisecond_divider_low;
	assign wr_millisecond_divider_high = sfr_wr_in && hit_millisecond_divider_high;
	assign wr_hms   = sfr_wr_in && hit_hms;
	assign wr_wdctl = sfr_wr_in && hit_wdctl;

	// upper bits of the prescaler are not stored, read as zero
	byte_t microsecond_prescaler_masked;
	assign microsecond_prescaler_masked = {3'h0,
		sfr_wdata_in[`PRESCALER_VALUE_MSB:0]};

	// no shadowing: a divisor takes effect at the next counter compare
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			microsecond_prescaler_reg <= `MICROSECOND_PRESCALER_RST;
		else if (wr_microsecond_prescaler)
			microsecond_prescaler_reg <= microsecond_prescaler_masked;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			millisecond_divider_low_reg <= `MILLISECOND_DIVIDER_LOW_RST;
		else if (wr_millisecond_divider_low)
			millisecond_divider_low_reg <= sfr_wdata_in;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			millisecond_divider_high_reg <= `MILLISECOND_DIVIDER_HIGH_RST;
		else if (wr_millisecond_divider_high)
			millisecond_divider_high_reg <= sfr_wdata_in;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			hms_reg <= `HUNDRED_MS_DIVIDER_RST;
		else if (wr_hms)
			hms_reg <= sfr_wdata_in;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			wdctl_reg <= `WATCHDOG_CONTROL_RST;
		else if (wr_wdctl)
			wdctl_reg <= sfr_wdata_in;
	end

	// =========================================================
	// read port
	byte_t rd_sel;

	assign rd_sel =
		hit_microsecond_prescaler  ? microsecond_prescaler_reg  :
		hit_millisecond_divider_low ? millisecond_divider_low_reg :
		hit_millisecond_divider_high ? millisecond_divider_high_reg :
		hit_hms   ? hms_reg   :
		hit_wdctl ? wdctl_reg :
		8'h00;

	// data holds until the next read strobe
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			sfr_rdata_out <= 8'h00;
		else if (sfr_rd_in)
			sfr_rdata_out <= rd_sel;
	end

	// =========================================================
	// divider chain
	assign tb_bus.microsecond_prescaler_div = microsecond_prescaler_reg[`PRESCALER_VALUE_MSB:0];
	assign tb_bus.msec_div = {millisecond_divider_high_reg, millisecond_divider_low_reg};
	assign tb_bus.hms_div  = hms_reg;
	assign tb_bus.run      = !timebase_power_down_in;

	timebase_divider_chain u_chain (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.tb         (tb_bus.gen)
	);

	// =========================================================
	// write-one-then-zero sequence detectors
	// a bit armed by a one completes on the next control write of zero;
	// stray writes elsewhere leave the arming untouched
	localparam int SEQ_POS [`WATCHDOG_SEQ_BITS] = '{
		`WATCHDOG_RESTART_BIT,
		`WATCHDOG_DISABLE_BIT,
		`WATCHDOG_ENABLE_BIT
	};

	logic [`WATCHDOG_SEQ_BITS-1:0] arm_reg;
	logic [`WATCHDOG_SEQ_BITS-1:0] arm_next;
	logic [`WATCHDOG_SEQ_BITS-1:0] seq_done;

	genvar gi;
	generate
		for (gi = 0; gi < `WATCHDOG_SEQ_BITS; gi++) begin : g_seq
			assign seq_done[gi] = wr_wdctl && arm_reg[gi] &&
				!sfr_wdata_in[SEQ_POS[gi]];
			assign arm_next[gi] = wr_wdctl ?
				sfr_wdata_in[SEQ_POS[gi]] : arm_reg[gi];
		end
	endgenerate

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			arm_reg <= '0;
		else
			arm_reg <= arm_next;
	end

	// =========================================================
	// watchdog counter
	wd_state_t state_reg;
	wd_state_t state_next;
	wd_count_t cnt_reg;
	wd_count_t cnt_next;
	wd_count_t cnt_load;
	logic      wd_run;
	logic      expire_hit;
	logic      do_stop;
	logic      do_reload;
	logic      do_count;

	// loading count+1 and expiring on the tick seen at zero gives
	// count+1 to count+2 tick periods, ticks being free-running
	assign cnt_load = {1'b0,
		wdctl_reg[`WATCHDOG_COUNT_MSB:0]} + 6'h01;
	assign wd_run = !watchdog_power_down_in;
	assign expire_hit = wd_run && (state_reg == WD_COUNTING) &&
		tb_bus.hms_tick && (cnt_reg == 6'h00);

	// stop outranks reload, so a combined write disables
	assign do_stop   = seq_done[`SEQ_DISABLE_IDX];
	assign do_reload = seq_done[`SEQ_RESTART_IDX] ||
		seq_done[`SEQ_ENABLE_IDX];
	assign do_count  = wd_run && tb_bus.hms_tick;
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			WD_IDLE: begin
				if (seq_done[`SEQ_RESTART_IDX])
					cnt_next = cnt_load;
				if (seq_done[`SEQ_ENABLE_IDX] &&
					!seq_done[`SEQ_DISABLE_IDX]) begin
					state_next = WD_COUNTING;
					cnt_next   = cnt_load;
				end
			end
			WD_COUNTING: begin
				if (do_stop)
					state_next = WD_IDLE;
				else if (do_reload)
					cnt_next = cnt_load;
				else if (expire_hit)
					state_next = WD_EXPIRED;
				else if (do_count)
					cnt_next = cnt_reg - 6'h01;
			end
			WD_EXPIRED: begin
				// held here; only software brings it out
				if (do_stop)
					state_next = WD_IDLE;
				else if (do_reload) begin
					state_next = WD_COUNTING;
					cnt_next   = cnt_load;
				end
			end
			default: begin
				state_next = WD_IDLE;
				cnt_next   = 6'h00;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			state_reg <= WD_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			cnt_reg <= 6'h00;
		else
			cnt_reg <= cnt_next;
	end

	// =========================================================
	// registered outputs
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			microsecond_prescaler_tick_out <= 1'b0;
		else
			microsecond_prescaler_tick_out <= tb_bus.microsecond_prescaler_tick;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			msec_tick_out <= 1'b0;
		else
			msec_tick_out <= tb_bus.msec_tick;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			hms_tick_out <= 1'b0;
		else
			hms_tick_out <= tb_bus.hms_tick;
	end

	// flag follows the next state so it lines up with the write
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			watchdog_counting_out <= 1'b0;
		else
			watchdog_counting_out <= (state_next != WD_IDLE);
	end

	// expiry pulses even when a restart lands in the same cycle
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			watchdog_event_out <= 1'b0;
		else
			watchdog_event_out <= expire_hit;
	end

endmodule

// File: timebase_prescaler_watchdog_props.sv
// checker for the timebase and watchdog block, top-level ports only
// assumes one clock domain; bound onto every instance of the top
`timescale 1ns/100ps

module timebase_prescaler_watchdog_props (
	// clock and reset
	input  wire logic                mclk_in,
	input  wire logic                sys_rst_in,
	// register port
	input  wire timebase_pkg::byte_t sfr_addr_in,
	input  wire logic                sfr_wr_in,
	input  wire timebase_pkg::byte_t sfr_wdata_in,
	input  wire logic                sfr_rd_in,
	input  wire timebase_pkg::byte_t sfr_rdata_out,
	// power-down and outputs
	input  wire logic                watchdog_power_down_in,
	input  wire logic                timebase_power_down_in,
	input  wire logic                microsecond_prescaler_tick_out,
	input  wire logic                msec_tick_out,
	input  wire logic                hms_tick_out,
	input  wire logic                watchdog_counting_out,
	input  wire logic                watchdog_event_out
);
	import timebase_pkg::*;
	logic ctl_wr;
	assign ctl_wr = sfr_wr_in && (sfr_addr_in == 8'hff);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	// =========================================================
	// watchdog
	property p_ev_pulse;
		watchdog_event_out |=> !watchdog_event_out;
	endproperty
	a_ev_pulse: assert property (p_ev_pulse)
		else $error("event longer than one cycle");
	property p_ev_cnt;
		watchdog_event_out |-> watchdog_counting_out;
	endproperty
	a_ev_cnt: assert property (p_ev_cnt)
		else $error("event while not counting");
	property p_wd_pd;
		watchdog_power_down_in [*3] |-> !watchdog_event_out;
	endproperty
	a_wd_pd: assert property (p_wd_pd)
		else $error("event while watchdog powered down");
	// two cycles of slack: write edge plus output flop
	property p_rise;
		$rose(watchdog_counting_out) |-> $past(ctl_wr && !sfr_wdata_in[7])
			|| $past(ctl_wr && !sfr_wdata_in[7], 2);
	endproperty
	a_rise: assert property (p_rise)
		else $error("counting started without enable write");
	property p_fall;
		$fell(watchdog_counting_out) |-> $past(ctl_wr && !sfr_wdata_in[6])
			|| $past(ctl_wr && !sfr_wdata_in[6], 2);
	endproperty
	a_fall: assert property (p_fall)
		else $error("counting stopped without disable write");

	// =========================================================
	// timebase and registers
	property p_tb_pd;
		timebase_power_down_in [*3] |->
			!microsecond_prescaler_tick_out && !msec_tick_out && !hms_tick_out;
	endproperty
	a_tb_pd: assert property (p_tb_pd)
		else $error("tick while timebase powered down");
	property p_unmapped;
		sfr_rd_in && sfr_addr_in < 8'hfb |=> sfr_rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_fb_high;
		sfr_rd_in && sfr_addr_in == 8'hfb |=> sfr_rdata_out[7:5] == 3'h0;
	endproperty
	a_fb_high: assert property (p_fb_high)
		else $error("prescaler upper bits not zero");
	property p_rd_hold;
		!sfr_rd_in |=> $stable(sfr_rdata_out);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without read");
endmodule

bind timebase_prescaler_watchdog timebase_prescaler_watchdog_props chk_u (
	.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
	.sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
	.sfr_rdata_out(sfr_rdata_out),
	.watchdog_power_down_in(watchdog_power_down_in),
	.timebase_power_down_in(timebase_power_down_in),
	.microsecond_prescaler_tick_out(microsecond_prescaler_tick_out), .msec_tick_out(msec_tick_out),
	.hms_tick_out(hms_tick_out),
	.watchdog_counting_out(watchdog_counting_out),
	.watchdog_event_out(watchdog_event_out)
);

// File: tb_timebase_prescaler_watchdog.sv
// self-checking bench for the timebase and watchdog block
// assumes the checker is bound in by its own file
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	failures++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

module tb_timebase_prescaler_watchdog;
	import timebase_pkg::*;
	logic       mclk_in, sys_rst_in, sfr_wr_in, sfr_rd_in;
	logic       watchdog_power_down_in, timebase_power_down_in;
	byte_t      sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
	wire  [4:0] sigs;
	int         failures = 0;
	int         n_tests = 0;
	int         n;
	byte_t      rst_vals [5] = '{8'h03, 8'h9f, 8'h0f, 8'h63, 8'h00};

	timebase_prescaler_watchdog dut_u (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
		.sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
		.sfr_rdata_out(sfr_rdata_out),
		.watchdog_power_down_in(watchdog_power_down_in),
		.timebase_power_down_in(timebase_power_down_in),
		.microsecond_prescaler_tick_out(sigs[0]), .msec_tick_out(sigs[1]),
		.hms_tick_out(sigs[2]), .watchdog_counting_out(sigs[4]),
		.watchdog_event_out(sigs[3]));

	// =========================================================
	// access tasks
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge mclk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge mclk_in);
		sfr_wr_in <= 1'b0;
	endtask
	task automatic rd(input byte_t a, input byte_t ex);
		@(posedge mclk_in);
		sfr_addr_in <= a;
		sfr_rd_in <= 1'b1;
		@(posedge mclk_in);
		sfr_rd_in <= 1'b0;
		@(negedge mclk_in);
		`CHK("rdata", ex, sfr_rdata_out)
	endtask
	// n = falling edges until output idx is high, capped at lim
	task automatic wait_for(input int idx, input int lim, input bit must);
		n = 0;
		@(negedge mclk_in);
		while (sigs[idx] !== 1'b1 && n < lim) begin
			@(negedge mclk_in);
			n++;
		end
		if (must && n >= lim) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic period(input int idx, input int ex);
		wait_for(idx, 2000, 1'b1);
		wait_for(idx, 2000, 1'b1);
		`CHK("tick_period", ex, n + 1)
	endtask
	// count 2, 16-cycle tick: 3..4 ticks plus the output flop
	task automatic expire();
		wait_for(3, 200, 1'b1);
		`CHK("expiry_window", 1'b1, n >= 49 && n <= 65)
	endtask
	task automatic end_of_test();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// =========================================================
	// stimulus
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	initial begin
		sys_rst_in = 1'b1;
		sfr_wr_in = 1'b0;
		sfr_rd_in = 1'b0;
		sfr_addr_in = 8'h00;
		sfr_wdata_in = 8'h00;
		watchdog_power_down_in = 1'b0;
		timebase_power_down_in = 1'b0;
		repeat (5) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(8'hfb + i[7:0], rst_vals[i]);
		end
		wr(8'h10, 8'h55);
		rd(8'h10, 8'h00);
		wr(8'hfb, 8'hff);
		rd(8'hfb, 8'h1f);
		wr(8'hfb, 8'h04);
		period(0, 5);
		wr(8'hfd, 8'h01);
		wr(8'hfc, 8'h02);
		period(1, 259);
		wr(8'hfe, 8'h02);
		period(2, 777);
		wr(8'hfd, 8'h00);
		wr(8'hfc, 8'h03);
		wr(8'hfe, 8'h03);
		wr(8'hff, 8'h82);
		@(negedge mclk_in);
		`CHK("counting", 1'b0, sigs[4])
		rd(8'hff, 8'h82);
		wr(8'hff, 8'h02);
		expire();
		wait_for(3, 100, 1'b0);
		`CHK("held", 100, n)
		`CHK("counting", 1'b1, sigs[4])
		wr(8'hff, 8'h22);
		wr(8'hff, 8'h02);
		expire();
		wr(8'hff, 8'h22);
		wr(8'hff, 8'h02);
		@(posedge mclk_in);
		watchdog_power_down_in <= 1'b1;
		wait_for(3, 150, 1'b0);
		`CHK("frozen", 150, n)
		@(posedge mclk_in);
		watchdog_power_down_in <= 1'b0;
		wait_for(3, 100, 1'b1);
		wr(8'hff, 8'h42);
		wr(8'hff, 8'h02);
		wait_for(3, 150, 1'b0);
		`CHK("disabled", 150, n)
		`CHK("counting", 1'b0, sigs[4])
		wr(8'hff, 8'h22);
		wr(8'hff, 8'h02);
		wr(8'hff, 8'hc2);
		wr(8'hff, 8'h02);
		@(negedge mclk_in);
		`CHK("idle_stays", 1'b0, sigs[4])
		rd(8'hff, 8'h02);
		@(posedge mclk_in);
		timebase_power_down_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		wait_for(0, 50, 1'b0);
		`CHK("stopped", 50, n)
		@(posedge mclk_in);
		timebase_power_down_in <= 1'b0;
		period(0, 5);
		end_of_test();
	end
endmodule
